// >>> inc/dpsb_pkg.sv
// What this block does
// RQ1: inputs sampled on rising edge; output enable asynchronous
// RQ2: output enable high floats data pins immediately
// RQ3: either chip enable inactive deselects, outputs float
// RQ4: selected: read/write low writes, high reads
// RQ5: pipelined: chip enable change acts one clock later
// RQ6: pipelined read data one cycle after flow-through
// RQ7: output state follows previous cycle controls
// RQ8: strobe low uses pins, high uses counter
// RQ9: strobe low loads counter, accesses address n
// RQ10: advance high holds counter, same location again
// RQ11: advance low increments counter to n+1
// RQ12: counter clear low forces zero, highest priority
// RQ13: counter clear inserts no idle cycle
// RQ14: counter ignores both chip enables
// RQ15: burst writes advance in both output modes
// RQ16: cross-port reader waits delay or setup plus access
// RQ17: rewrite location after a no-operation cycle
// RQ18: depth expansion shares address, chip enables select
// RQ19: selected only with both chip enables active
// RQ20: reader allows 40 ns after writer edge
// RQ21: output mode select held static
// RQ22: counter spans array, wraps to zero
// RQ23: byte selects gate each nine-bit half
package dpsb_pkg;
  localparam int DATA_W = 18;
  localparam int HALF_W = 9;
  localparam int ADDR_W = 13;
  localparam int DEPTH = 8192;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 13'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 13'h0001;
  localparam logic [DATA_W-1:0] DATA_ZERO = 18'h00000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int WRITE_TO_READ_DELAY_NS = 40;
  localparam int CLOCK_TO_CLOCK_SETUP_NS = 15;
  localparam int FLOWTHROUGH_ACCESS_TIME_NS = 20;
  // least waits round up, at least one cycle
  localparam int WRITE_TO_READ_CYC =
    (WRITE_TO_READ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_PLUS_ACCESS_CYC =
    (CLOCK_TO_CLOCK_SETUP_NS + FLOWTHROUGH_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // host waits this many cycles from a write before trusting readback on the other port
  localparam int CROSS_WAIT_CYC = (WRITE_TO_READ_CYC > SETUP_PLUS_ACCESS_CYC)
    ? WRITE_TO_READ_CYC : SETUP_PLUS_ACCESS_CYC;
  localparam logic [1:0] WAIT_CNT = 2'(CROSS_WAIT_CYC);
  localparam logic [1:0] WAIT_ZERO = 2'h0;
  localparam logic [1:0] WAIT_ONE = 2'h1;

  // selection needs both enables at their active levels
  function automatic logic dpsb_selected(input logic cs_n, input logic cs);
    dpsb_selected = !cs_n && cs;
  endfunction : dpsb_selected
endpackage : dpsb_pkg

// >>> inc/dpsb_if.sv
`timescale 1ns/10ps
interface dpsb_if;
  logic chip_select_low_active;
  logic chip_select_high_active;
  logic rw;
  logic address_strobe_load;
  logic counter_advance_enable_n;
  logic counter_clear_n;
  logic upper_byte_select;
  logic lower_byte_select;
  logic out_enable_n;
  logic flow_through_select;
  logic [dpsb_pkg::ADDR_W-1:0] addr;
  logic [dpsb_pkg::DATA_W-1:0] host_dq_o;
  logic host_dq_oe;
  logic [dpsb_pkg::DATA_W-1:0] mem_dq_o;
  logic [1:0] mem_dq_oe;
  // resolved pin level: whichever side drives, else zero in place of float
  logic [dpsb_pkg::DATA_W-1:0] dq_mem_in;
  logic [dpsb_pkg::DATA_W-1:0] dq_host_in;
  assign dq_mem_in = host_dq_oe ? host_dq_o : dpsb_pkg::DATA_ZERO;
  assign dq_host_in = {mem_dq_oe[1] ? mem_dq_o[17:9] : 9'h000, mem_dq_oe[0] ? mem_dq_o[8:0] : 9'h000};

  modport mem (
    input chip_select_low_active, chip_select_high_active, rw, address_strobe_load,
    input counter_advance_enable_n, counter_clear_n, upper_byte_select, lower_byte_select,
    input out_enable_n, flow_through_select, addr, dq_mem_in,
    output mem_dq_o, mem_dq_oe
  );
  modport host (
    output chip_select_low_active, chip_select_high_active, rw, address_strobe_load,
    output counter_advance_enable_n, counter_clear_n, upper_byte_select, lower_byte_select,
    output out_enable_n, flow_through_select, addr, host_dq_o, host_dq_oe,
    input dq_host_in
  );
endinterface : dpsb_if

// >>> rtl/dpsb_burst_counter.sv
`timescale 1ns/10ps
module dpsb_burst_counter (
  // clock
  input wire logic core_clk,
  input wire logic rst,
  // controls
  input wire logic address_strobe_load,
  input wire logic counter_advance_enable_n,
  input wire logic counter_clear_n,
  input wire logic [dpsb_pkg::ADDR_W-1:0] ext_addr,
  // result
  output logic [dpsb_pkg::ADDR_W-1:0] access_addr,
  output logic [dpsb_pkg::ADDR_W-1:0] count
);
  // address used by this edge's access
  always_comb
  begin
    if (!counter_clear_n)
      access_addr = dpsb_pkg::ADDR_ZERO; // RQ12 RQ13
    else if (!address_strobe_load)
      access_addr = ext_addr; // RQ8 RQ9
    else if (!counter_advance_enable_n)
      access_addr = count + dpsb_pkg::ADDR_ONE; // RQ11 RQ22
    else
      access_addr = count; // RQ10
  end

  // counter keeps the last accessed address; chip enables never gate it
  always_ff @(posedge core_clk)
  begin
    if (rst)
      count <= dpsb_pkg::ADDR_ZERO;
    else
      count <= access_addr; // RQ14
  end
endmodule : dpsb_burst_counter

// >>> rtl/dpsb_mem_port.sv
`timescale 1ns/10ps
module dpsb_mem_port (
  // clock
  input wire logic core_clk,
  input wire logic rst,
  // pin side
  dpsb_if.mem pins,
  // user side: second-port view of the array, plus the burst counter value
  input wire logic [dpsb_pkg::ADDR_W-1:0] peer_addr,
  output logic [dpsb_pkg::DATA_W-1:0] peer_rdata,
  output logic [dpsb_pkg::ADDR_W-1:0] burst_count
);
  logic [dpsb_pkg::DATA_W-1:0] array [dpsb_pkg::DEPTH];
  logic [dpsb_pkg::ADDR_W-1:0] access_addr;
  logic sel;
  logic rd_ft;
  logic [1:0] lane_ft;
  logic [dpsb_pkg::DATA_W-1:0] data_ft;
  logic rd_pp;
  logic [1:0] lane_pp;
  logic [dpsb_pkg::DATA_W-1:0] data_pp;
  logic [dpsb_pkg::DATA_W-1:0] rd_word;
  logic [1:0] drive_lanes;

  dpsb_burst_counter u_cnt (
    .core_clk(core_clk),
    .rst(rst),
    .address_strobe_load(pins.address_strobe_load),
    .counter_advance_enable_n(pins.counter_advance_enable_n),
    .counter_clear_n(pins.counter_clear_n),
    .ext_addr(pins.addr),
    .access_addr(access_addr),
    .count(burst_count)
  );

  assign sel = dpsb_pkg::dpsb_selected(pins.chip_select_low_active, pins.chip_select_high_active); // RQ19
  assign rd_word = array[access_addr];

  // byte-gated write on the sampling edge
  always_ff @(posedge core_clk)
  begin
    if (sel && !pins.rw)
    begin
      if (pins.upper_byte_select)
        array[access_addr][17:9] <= pins.dq_mem_in[17:9]; // RQ4 RQ15 RQ23
      if (pins.lower_byte_select)
        array[access_addr][8:0] <= pins.dq_mem_in[8:0]; // RQ23
    end
  end

  // flow-through stage: output state set by last edge's controls
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rd_ft <= 1'b0;
      lane_ft <= 2'b00;
      data_ft <= dpsb_pkg::DATA_ZERO;
    end
    else
    begin
      rd_ft <= sel && pins.rw; // RQ1 RQ3 RQ7
      lane_ft <= {pins.upper_byte_select, pins.lower_byte_select};
      data_ft <= rd_word; // RQ4
    end
  end

  // pipelined stage adds one cycle to data and to select changes
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rd_pp <= 1'b0;
      lane_pp <= 2'b00;
      data_pp <= dpsb_pkg::DATA_ZERO;
    end
    else
    begin
      rd_pp <= rd_ft; // RQ5
      lane_pp <= lane_ft;
      data_pp <= data_ft; // RQ6
    end
  end

  // mode pin is static so switching mid-burst is not handled
  assign drive_lanes = pins.flow_through_select ? (rd_ft ? lane_ft : 2'b00) : (rd_pp ? lane_pp : 2'b00); // RQ21
  assign pins.mem_dq_o = pins.flow_through_select ? data_ft : data_pp;
  // output enable gates without a clock
  assign pins.mem_dq_oe = pins.out_enable_n ? 2'b00 : drive_lanes; // RQ2

  // second port reads the same array; cross-port timing is the host's job
  always_ff @(posedge core_clk)
  begin
    if (rst)
      peer_rdata <= dpsb_pkg::DATA_ZERO;
    else
      peer_rdata <= array[peer_addr];
  end
endmodule : dpsb_mem_port

// >>> rtl/dpsb_host.sv
`timescale 1ns/10ps
module dpsb_host (
  // clock
  input wire logic core_clk,
  input wire logic rst,
  // pin side
  dpsb_if.host pins,
  // user request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_burst,
  input wire logic req_clear,
  input wire logic [dpsb_pkg::ADDR_W-1:0] req_addr,
  input wire logic [dpsb_pkg::DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_lanes,
  input wire logic req_bank,
  input wire logic mode_flow_through,
  // user answer
  output logic rsp_valid,
  output logic [dpsb_pkg::DATA_W-1:0] rsp_rdata,
  output logic cross_ready
);
  logic [2:0] rd_track;
  logic [1:0] wait_cnt;

  // drive pins one request per cycle, all but out_enable_n sampled by the memory on the next edge
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pins.chip_select_low_active <= 1'b1;
      pins.chip_select_high_active <= 1'b0;
      pins.rw <= 1'b1;
      pins.address_strobe_load <= 1'b0;
      pins.counter_advance_enable_n <= 1'b1;
      pins.counter_clear_n <= 1'b1;
      pins.upper_byte_select <= 1'b0;
      pins.lower_byte_select <= 1'b0;
      pins.out_enable_n <= 1'b1;
      pins.addr <= dpsb_pkg::ADDR_ZERO;
      pins.host_dq_o <= dpsb_pkg::DATA_ZERO;
      pins.host_dq_oe <= 1'b0;
    end
    else
    begin
      // bank select through the enables, shared address
      pins.chip_select_low_active <= !(req_valid && !req_bank); // RQ18 RQ19
      pins.chip_select_high_active <= req_valid && !req_bank;
      pins.rw <= !(req_valid && req_write);
      // idle cycles hold the counter, else a held burst level would keep advancing it
      pins.address_strobe_load <= !req_valid || req_burst;
      pins.counter_advance_enable_n <= !(req_valid && req_burst);
      pins.counter_clear_n <= !(req_valid && req_clear);
      pins.upper_byte_select <= req_lanes[1];
      pins.lower_byte_select <= req_lanes[0];
      pins.out_enable_n <= req_valid && req_write; // avoid fighting the data pins
      pins.addr <= req_addr;
      pins.host_dq_o <= req_wdata;
      pins.host_dq_oe <= req_valid && req_write;
    end
  end

  // mode pin follows the user input directly; the user must hold it static
  assign pins.flow_through_select = mode_flow_through; // RQ21

  // one bit per edge since the request, so back-to-back reads each get an answer
  always_ff @(posedge core_clk)
  begin
    if (rst)
      rd_track <= 3'h0;
    else
      rd_track <= {rd_track[1:0], req_valid && !req_write && !req_bank};
  end

  // capture after flow-through or pipelined latency
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= dpsb_pkg::DATA_ZERO;
    end
    else
    begin
      // capture at the edge that ends the cycle in which the memory drives the word
      rsp_valid <= mode_flow_through ? rd_track[1] : rd_track[2]; // RQ6
      rsp_rdata <= pins.dq_host_in;
    end
  end

  // other port must wait after a write before trusting the word
  always_ff @(posedge core_clk)
  begin
    if (rst)
      wait_cnt <= dpsb_pkg::WAIT_ZERO;
    else if (req_valid && req_write)
      wait_cnt <= dpsb_pkg::WAIT_CNT; // RQ16 RQ20
    else if (wait_cnt != dpsb_pkg::WAIT_ZERO)
      wait_cnt <= wait_cnt - dpsb_pkg::WAIT_ONE;
  end

  // user should rewrite after a no-op cycle before trusting that word
  always_ff @(posedge core_clk)
  begin
    if (rst)
      cross_ready <= 1'b0;
    else
      cross_ready <= (wait_cnt == dpsb_pkg::WAIT_ZERO) && !(req_valid && req_write); // RQ17
  end
endmodule : dpsb_host

// >>> sim/dpsb_sva.sv
`timescale 1ns/10ps
module dpsb_sva (
  // clock
  input wire logic core_clk,
  input wire logic rst,
  // pins
  input wire logic chip_select_low_active,
  input wire logic chip_select_high_active,
  input wire logic rw,
  input wire logic upper_byte_select,
  input wire logic lower_byte_select,
  input wire logic out_enable_n,
  input wire logic flow_through_select,
  input wire logic [1:0] mem_dq_oe
);
  logic sel;
  // select needs both enables; one gate serves every check except the output-enable and mode checks
  assign sel = !chip_select_low_active && chip_select_high_active;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_oe_float: assert property (out_enable_n |-> mem_dq_oe == 2'h0)
    else $error("data driven while output enable high");
  a_ft_deselect: assert property (!sel && flow_through_select |=> mem_dq_oe == 2'h0)
    else $error("flow-through deselect still drives");
  a_pipe_deselect: assert property (!sel && !flow_through_select |-> ##2 mem_dq_oe == 2'h0)
    else $error("pipelined deselect still drives");
  a_write_quiet: assert property (sel && !rw && flow_through_select |=> mem_dq_oe == 2'h0)
    else $error("write cycle drives data");
  a_ft_read: assert property (sel && rw && upper_byte_select && lower_byte_select && flow_through_select
    ##1 !out_enable_n |-> mem_dq_oe == 2'h3)
    else $error("flow-through read not driven");
  a_pipe_read: assert property (sel && rw && upper_byte_select && lower_byte_select && !flow_through_select
    ##2 !out_enable_n |-> mem_dq_oe == 2'h3)
    else $error("pipelined read not driven");
  a_upper_gate: assert property (sel && rw && !upper_byte_select && flow_through_select |=> !mem_dq_oe[1])
    else $error("upper half driven without its select");
  a_mode_static: assert property ($stable(flow_through_select))
    else $error("mode select changed in operation");
endmodule : dpsb_sva

// >>> sim/tb.sv
`timescale 1ns/10ps
module tb;
  logic core_clk, rst, req_valid, req_write, req_burst, req_clear, req_bank, mode_flow_through, rsp_valid;
  logic cross_ready;
  logic [12:0] req_addr, peer_addr, cnt, burst_count;
  logic [17:0] req_wdata, rsp_rdata, peer_rdata;
  logic [17:0] mdl [0:8191];
  logic [1:0] req_lanes;
  int errors, check_count, lat, lt0, lt1, i, m;
  dpsb_if pins_if ();
  dpsb_mem_port dpsb_mem_port_inst (.core_clk(core_clk), .rst(rst), .pins(pins_if), .peer_addr(peer_addr),
    .peer_rdata(peer_rdata), .burst_count(burst_count));
  dpsb_host dpsb_host_inst (.core_clk(core_clk), .rst(rst), .pins(pins_if), .req_valid(req_valid),
    .req_write(req_write), .req_burst(req_burst), .req_clear(req_clear), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_lanes(req_lanes), .req_bank(req_bank), .mode_flow_through(mode_flow_through),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .cross_ready(cross_ready));
  dpsb_sva dpsb_sva_inst (.core_clk(core_clk), .rst(rst),
    .chip_select_low_active(pins_if.chip_select_low_active), .chip_select_high_active(pins_if.chip_select_high_active),
    .rw(pins_if.rw), .upper_byte_select(pins_if.upper_byte_select), .lower_byte_select(pins_if.lower_byte_select),
    .out_enable_n(pins_if.out_enable_n), .flow_through_select(pins_if.flow_through_select),
    .mem_dq_oe(pins_if.mem_dq_oe));
  // free-running 20 MHz clock
  always #25 core_clk = ~core_clk;
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // one request; model tracks counter and array, compares every answer
  task automatic op(input logic wr, bur, clr, bank, input logic [12:0] a, input logic [17:0] d,
    input logic [1:0] ln);
    int n;
    logic [12:0] ea;
    logic [17:0] ex;
    ea = clr ? 13'h0000 : (bur ? cnt + 13'h0001 : a);
    cnt = ea;
    if (wr && !bank && ln[1])
      mdl[ea][17:9] = d[17:9];
    if (wr && !bank && ln[0])
      mdl[ea][8:0] = d[8:0];
    ex = {ln[1] ? mdl[ea][17:9] : 9'h000, ln[0] ? mdl[ea][8:0] : 9'h000};
    {req_valid, req_write, req_burst, req_clear, req_bank} = {1'b1, wr, bur, clr, bank};
    {req_addr, req_wdata, req_lanes} = {a, d, ln};
    @(negedge core_clk);
    req_valid = 1'b0;
    peer_addr = ea;
    n = 1;
    if (!wr)
    begin
      while (rsp_valid !== 1'b1 && n < 20)
      begin
        @(negedge core_clk);
        n++;
      end
      chk("rsp_valid", rsp_valid, 1'h1);
      chk("rdata", rsp_rdata, ex);
      lat = n;
    end
    else
    begin
      chk("cross_ready", cross_ready, 1'h0);
      repeat (4) @(negedge core_clk);
      chk("peer", peer_rdata, mdl[ea]);
      chk("cross_ready", cross_ready, 1'h1);
    end
    chk("count", burst_count, cnt);
  endtask : op
  // watchdog far beyond the expected run length
  initial
  begin
    #200000;
    errors++;
    summarize();
  end
  // both output modes, each after its own reset
  initial
  begin
    {core_clk, rst, mode_flow_through, peer_addr} = {1'b0, 1'b1, 1'b1, 13'h0000};
    {req_valid, req_write, req_burst, req_clear, req_bank} = 5'h00;
    {req_addr, req_wdata, req_lanes} = 33'h0;
    errors = 0;
    check_count = 0;
    void'($urandom(53));
    for (m = 0; m < 2; m++)
    begin
      rst = 1'b1;
      mode_flow_through = (m == 0);
      repeat (8) @(negedge core_clk);
      rst = 1'b0;
      cnt = 13'h0000;
      for (i = 0; i < 6; i++)
      begin
        req_addr = 13'($urandom);
        op(1'b1, 1'b0, 1'b0, 1'b0, req_addr, 18'($urandom), 2'h3);
        op(1'b0, 1'b0, 1'b0, 1'b0, req_addr, 18'h00000, 2'h3);
      end
      if (m == 0)
        lt0 = lat;
      else
        lt1 = lat;
      op(1'b1, 1'b0, 1'b0, 1'b0, 13'h1FFF, 18'($urandom), 2'h3);
      op(1'b1, 1'b1, 1'b0, 1'b0, 13'h0555, 18'($urandom), 2'h3);
      op(1'b1, 1'b1, 1'b0, 1'b0, 13'h0AAA, 18'($urandom), 2'h3);
      op(1'b0, 1'b0, 1'b0, 1'b0, 13'h1FFF, 18'h00000, 2'h3);
      op(1'b0, 1'b0, 1'b1, 1'b0, 13'h0777, 18'h00000, 2'h3);
      op(1'b0, 1'b1, 1'b0, 1'b0, 13'h1234, 18'h00000, 2'h3);
      op(1'b1, 1'b0, 1'b0, 1'b0, 13'h0001, 18'($urandom), 2'($urandom_range(1, 2)));
      op(1'b0, 1'b0, 1'b0, 1'b0, 13'h0001, 18'h00000, 2'($urandom_range(1, 3)));
      op(1'b0, 1'b0, 1'b0, 1'b0, 13'h0001, 18'h00000, 2'h1);
      op(1'b1, 1'b0, 1'b0, 1'b1, 13'h0001, 18'($urandom), 2'h3);
      op(1'b0, 1'b0, 1'b0, 1'b0, 13'h0001, 18'h00000, 2'h3);
    end
    chk("latency", 32'(lt1), 32'(lt0 + 1));
    summarize();
  end
endmodule : tb
